// [tcc_pkg.sv]
// Package for the timer channel capture/compare block: register map, fields, types.
// Assumes an APB slave with 32-bit data; each register takes one aligned word.
package tcc_pkg;

   // -----------------------------------------------------------------
   // Register byte addresses
   // -----------------------------------------------------------------
   localparam logic [7:0] CH0_CTRL_OFS = 8'h00;
   localparam logic [7:0] CH1_CTRL_OFS = 8'h04;
   localparam logic [7:0] CH0_HI_OFS = 8'h08;
   localparam logic [7:0] CH0_LO_OFS = 8'h0c;
   localparam logic [7:0] CH1_HI_OFS = 8'h10;
   localparam logic [7:0] CH1_LO_OFS = 8'h14;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
   localparam logic [7:0] IRQ_CLR_OFS = 8'h1c;
   localparam logic [7:0] IRQ_EN_OFS = 8'h20;
   localparam logic [7:0] TMR_CTRL_OFS = 8'h24;

   // -----------------------------------------------------------------
   // Channel control field positions
   // -----------------------------------------------------------------
   localparam int FULL_DUTY_BIT = 0;
   localparam int TOV_BIT = 1;
   localparam int ELS_LO_BIT = 2;
   localparam int ELS_HI_BIT = 3;
   localparam int MODE_A_BIT = 4;
   localparam int BUF_BIT = 5;
   localparam int FLAG_BIT = 7;
   localparam logic [5:0] CTRL_RESET = 6'h00;

   // Timer control: bit 0 halts the counter, bit 1 clears it.
   localparam int HALT_BIT = 0;
   localparam int CLEAR_BIT = 1;
   localparam logic [1:0] TMR_CTRL_RESET = 2'h1;
   localparam logic [15:0] MODULO_RESET = 16'hffff;

   // Pin action selected by the edge/level pair.
   typedef enum logic [1:0] {
      TCC_ACT_NONE = 2'h0,
      TCC_ACT_TOGGLE = 2'h1,
      TCC_ACT_CLEAR = 2'h2,
      TCC_ACT_SET = 2'h3
   } tcc_act_t;

   typedef struct packed {
      logic buffered;
      logic mode_a;
      logic els_hi;
      logic els_lo;
      logic toggle_on_wrap;
      logic full_duty_force;
   } tcc_ctrl_t;

   typedef struct packed {
      logic drive;
      logic level;
   } tcc_pin_t;

endpackage : tcc_pkg

// [tcc_sync.sv]
// Three-stage synchroniser for a channel pin with agreement filter.
// Assumes the pin is asynchronous to sys_clk.
module tcc_sync (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic pin_in,
   output logic level_out
);
   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic level_reg;
   logic level_next;

   always_comb begin
      stage_next = {stage_reg[1:0], pin_in};
      level_next = level_reg;
      // A change counts once the second and third stages agree.
      if (stage_reg[1] == stage_reg[2]) begin
         level_next = stage_reg[2];
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage_reg <= 3'h0;
         level_reg <= 1'b0;
      end else begin
         stage_reg <= stage_next;
         level_reg <= level_next;
      end
   end

   assign level_out = level_reg;
endmodule // tcc_sync

// [tcc_chan.sv]
// One capture/compare channel: edge detection, capture, compare and pin action.
// Assumes the counter and wrap pulse arrive from the timer core on sys_clk.
module tcc_chan (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire tcc_pkg::tcc_ctrl_t ctrl,
   input wire logic active,
   input wire logic pin_level,
   input wire logic [15:0] counter,
   input wire logic wrap,
   input wire logic [15:0] cmp_value,
   input wire logic capture_block,
   input wire logic compare_block,
   output logic capture_pulse,
   output logic event_pulse,
   output tcc_pkg::tcc_pin_t pin
);
   logic prev_reg;
   logic prev_next;
   tcc_pkg::tcc_pin_t pin_reg;
   tcc_pkg::tcc_pin_t pin_next;
   logic max_reg;
   logic max_next;
   logic connected;
   logic capture_mode;
   logic rise;
   logic fall;
   logic edge_hit;
   logic match;
   tcc_pkg::tcc_act_t act;

   always_comb begin
      connected = active && (ctrl.els_hi || ctrl.els_lo);
      capture_mode = !ctrl.buffered && !ctrl.mode_a;
      rise = pin_level && !prev_reg;
      fall = !pin_level && prev_reg;
      edge_hit = (ctrl.els_lo && rise) || (ctrl.els_hi && fall);
      capture_pulse = connected && capture_mode && edge_hit && !capture_block;
      match = connected && !capture_mode && (counter == cmp_value) && !compare_block;
      event_pulse = capture_pulse || match;
      act = tcc_pkg::tcc_act_t'({ctrl.els_hi, ctrl.els_lo});
      prev_next = pin_level;
      max_next = max_reg;
      pin_next.drive = connected && !capture_mode;
      pin_next.level = pin_reg.level;
      if (!connected) begin
         pin_next.level = !ctrl.mode_a;
      end else if (!capture_mode) begin
         if (wrap) begin
            max_next = ctrl.full_duty_force && !ctrl.toggle_on_wrap;
         end
         if (wrap && ctrl.toggle_on_wrap) begin
            pin_next.level = !pin_reg.level;
         end else if (max_reg) begin
            pin_next.level = 1'b1;
         end else if (match) begin
            case (act)
               tcc_pkg::TCC_ACT_TOGGLE: pin_next.level = !pin_reg.level;
               tcc_pkg::TCC_ACT_CLEAR: pin_next.level = 1'b0;
               tcc_pkg::TCC_ACT_SET: pin_next.level = 1'b1;
               default: pin_next.level = pin_reg.level;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prev_reg <= 1'b0;
         max_reg <= 1'b0;
         pin_reg <= '0;
      end else begin
         prev_reg <= prev_next;
         max_reg <= max_next;
         pin_reg <= pin_next;
      end
   end

   assign pin = pin_reg;
endmodule // tcc_chan

// [tcc_top.sv]
// Top of the two-channel timer capture/compare block with its APB register file.
// Assumes an APB master on sys_clk and external circuitry on the channel pins.
//
// Contract
// - With edge bits nonzero, mode-A picks capture (0) or compare/PWM (1).
// - With edge bits zero, mode-A sets preset level: 1 low, 0 high.
// - Edge bits both clear detach channel from its pin.
// - In capture, edge bits pick rising, falling or either edge.
// - In compare, edge bits pick toggle, clear or set; else none.
// - Buffered mode performs compare/PWM with the same pin actions.
// - Toggle-on-wrap toggles pin at each overflow in compare mode.
// - Overflow action beats a simultaneous compare match.
// - Full-duty bit forces PWM to full duty when toggle is off.
// - Full-duty changes take effect from the next period.
// - Value register holds capture or compare value; reset undefined.
// - Capture mode: high byte read blocks captures until low byte read.
// - Compare mode: high byte write blocks matches until low byte write.
// - Reset clears mode-A, edge bits and toggle-on-wrap.
// - Buffered channel 0 disables channel 1 control and pin.
// - Event flag sets on capture edge or compare equality.
module tcc_top #(
   parameter int CH_NUM = 2
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [CH_NUM-1:0] channel_pin_in,
   output logic [CH_NUM-1:0] channel_pin_out,
   output logic [CH_NUM-1:0] channel_pin_oe,
   output logic irq
);
   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   tcc_pkg::tcc_ctrl_t ctrl_reg [CH_NUM];
   tcc_pkg::tcc_ctrl_t ctrl_next [CH_NUM];
   logic [15:0] value_reg [CH_NUM];
   logic [15:0] value_next [CH_NUM];
   logic [CH_NUM-1:0] cap_blk_reg, cap_blk_next, cmp_blk_reg, cmp_blk_next;
   logic [CH_NUM-1:0] status_reg, status_next, enable_reg, enable_next;
   logic [1:0] tmr_reg, tmr_next;
   logic [15:0] count_reg, count_next;
   logic [15:0] modulo_reg, modulo_next;
   logic sel_reg, sel_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next, pslverr_reg, pslverr_next, irq_reg, irq_next;
   logic [CH_NUM-1:0] pin_out_reg, pin_out_next, pin_oe_reg, pin_oe_next;

   logic [CH_NUM-1:0] level, cap_pulse, evt_pulse, active;
   tcc_pkg::tcc_pin_t pin_w [CH_NUM];
   logic [15:0] cmp_w [CH_NUM];
   logic wrap, buf0, wr, rd, setup;

   assign buf0 = ctrl_reg[0].buffered;
   assign wrap = !tmr_reg[tcc_pkg::HALT_BIT] && (count_reg == modulo_reg);

   // -----------------------------------------------------------------
   // Channels
   // -----------------------------------------------------------------
   for (genvar i = 0; i < CH_NUM; i++) begin : g_ch
      assign active[i] = !(i == 1 && buf0);
      assign cmp_w[i] = (i == 0 && buf0) ? value_reg[sel_reg] : value_reg[i];
      tcc_sync u_sync (
         .sys_clk(sys_clk),
         .sys_rst(sys_rst),
         .pin_in(channel_pin_in[i]),
         .level_out(level[i])
      );
      tcc_chan u_chan (
         .sys_clk(sys_clk),
         .sys_rst(sys_rst),
         .ctrl(ctrl_reg[i]),
         .active(active[i]),
         .pin_level(level[i]),
         .counter(count_reg),
         .wrap(wrap),
         .cmp_value(cmp_w[i]),
         .capture_block(cap_blk_reg[i]),
         .compare_block(cmp_blk_reg[i]),
         .capture_pulse(cap_pulse[i]),
         .event_pulse(evt_pulse[i]),
         .pin(pin_w[i])
      );
   end

   // -----------------------------------------------------------------
   // Register file and timer core
   // -----------------------------------------------------------------
   always_comb begin
      setup = psel && !penable;
      wr = psel && penable && pwrite;
      rd = psel && penable && !pwrite;
      tmr_next = tmr_reg;
      modulo_next = modulo_reg;
      count_next = count_reg;
      sel_next = sel_reg;
      status_next = status_reg;
      enable_next = enable_reg;
      cap_blk_next = cap_blk_reg;
      cmp_blk_next = cmp_blk_reg;
      pready_next = setup;
      pslverr_next = 1'b0;
      prdata_next = 32'h0;
      for (int i = 0; i < CH_NUM; i++) begin
         ctrl_next[i] = ctrl_reg[i];
         value_next[i] = value_reg[i];
         if (cap_pulse[i]) begin
            value_next[i] = count_reg;
         end
         pin_out_next[i] = pin_w[i].level;
         pin_oe_next[i] = pin_w[i].drive;
      end
      // Counter with clear and halt.
      if (tmr_reg[tcc_pkg::CLEAR_BIT]) begin
         count_next = 16'h0000;
         tmr_next[tcc_pkg::CLEAR_BIT] = 1'b0;
      end else if (wrap) begin
         count_next = 16'h0000;
         sel_next = !sel_reg;
      end else if (!tmr_reg[tcc_pkg::HALT_BIT]) begin
         count_next = count_reg + 16'h0001;
      end
      if (!buf0) begin
         sel_next = 1'b0;
      end
      if (setup) begin
         case (paddr)
            tcc_pkg::CH0_CTRL_OFS, tcc_pkg::CH1_CTRL_OFS: begin
               prdata_next = {24'h0, status_reg[paddr[2]], 1'b0, ctrl_reg[paddr[2]]};
            end
            tcc_pkg::CH0_HI_OFS, tcc_pkg::CH1_HI_OFS: begin
               prdata_next = {24'h0, value_reg[paddr[4]][15:8]};
            end
            tcc_pkg::CH0_LO_OFS, tcc_pkg::CH1_LO_OFS: begin
               prdata_next = {24'h0, value_reg[paddr[4]][7:0]};
            end
            tcc_pkg::IRQ_STAT_OFS: prdata_next = {30'h0, status_reg};
            tcc_pkg::IRQ_EN_OFS: prdata_next = {30'h0, enable_reg};
            tcc_pkg::TMR_CTRL_OFS: prdata_next = {30'h0, tmr_reg};
            tcc_pkg::IRQ_CLR_OFS: prdata_next = 32'h0;
            default: pslverr_next = 1'b1;
         endcase
      end
      if (psel && penable) begin
         case (paddr)
            tcc_pkg::CH0_CTRL_OFS, tcc_pkg::CH1_CTRL_OFS: begin
               if (wr && !(paddr[2] && buf0)) begin
                  ctrl_next[paddr[2]] = pwdata[5:0];
               end
            end
            tcc_pkg::CH0_HI_OFS, tcc_pkg::CH1_HI_OFS: begin
               if (wr) begin
                  value_next[paddr[4]][15:8] = pwdata[7:0];
                  if (ctrl_reg[paddr[4]].buffered || ctrl_reg[paddr[4]].mode_a) begin
                     cmp_blk_next[paddr[4]] = 1'b1;
                  end
               end else if (!ctrl_reg[paddr[4]].buffered && !ctrl_reg[paddr[4]].mode_a) begin
                  cap_blk_next[paddr[4]] = 1'b1;
               end
            end
            tcc_pkg::CH0_LO_OFS, tcc_pkg::CH1_LO_OFS: begin
               if (wr) begin
                  value_next[paddr[4]][7:0] = pwdata[7:0];
                  cmp_blk_next[paddr[4]] = 1'b0;
               end else begin
                  cap_blk_next[paddr[4]] = 1'b0;
               end
            end
            tcc_pkg::IRQ_EN_OFS: if (wr) enable_next = pwdata[CH_NUM-1:0];
            tcc_pkg::IRQ_CLR_OFS: if (wr) status_next = status_reg & ~pwdata[CH_NUM-1:0];
            tcc_pkg::TMR_CTRL_OFS: if (wr) tmr_next = pwdata[1:0];
            default: ;
         endcase
      end
      status_next = status_next | evt_pulse;
      irq_next = |(status_next & enable_next);
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < CH_NUM; i++) begin
            ctrl_reg[i] <= tcc_pkg::CTRL_RESET;
         end
         tmr_reg <= tcc_pkg::TMR_CTRL_RESET;
         modulo_reg <= tcc_pkg::MODULO_RESET;
         count_reg <= 16'h0000;
         sel_reg <= 1'b0;
         status_reg <= '0;
         enable_reg <= '0;
         cap_blk_reg <= '0;
         cmp_blk_reg <= '0;
         prdata_reg <= 32'h0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         irq_reg <= 1'b0;
         pin_out_reg <= '0;
         pin_oe_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         tmr_reg <= tmr_next;
         modulo_reg <= modulo_next;
         count_reg <= count_next;
         sel_reg <= sel_next;
         status_reg <= status_next;
         enable_reg <= enable_next;
         cap_blk_reg <= cap_blk_next;
         cmp_blk_reg <= cmp_blk_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         irq_reg <= irq_next;
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
      end
   end

   // Value registers hold no reset, matching their undefined power-up state.
   always_ff @(posedge sys_clk) begin
      value_reg <= value_next;
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_reg;
   assign channel_pin_out = pin_out_reg;
   assign channel_pin_oe = pin_oe_reg;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   sequence apb_setup_s;
      psel && !penable;
   endsequence

   sequence apb_access_s;
      psel && penable && pready;
   endsequence

   apb_answer_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      apb_setup_s |=> apb_access_s)
      else $error("APB answer not one cycle after setup");

   detach_pin_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!ctrl_reg[0].els_hi && !ctrl_reg[0].els_lo) |-> ##2 !channel_pin_oe[0])
      else $error("Detached channel still drives pin");

   preset_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!ctrl_reg[0].els_hi && !ctrl_reg[0].els_lo)[*3] |-> channel_pin_out[0] == !$past(ctrl_reg[0].mode_a, 2))
      else $error("Preset level wrong");

   flag_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      evt_pulse[0] |=> status_reg[0])
      else $error("Event did not set flag");

   irq_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (status_reg[0] && enable_reg[0]) |-> ##[0:1] irq)
      else $error("Interrupt missing for enabled flag");

   ch1_lock_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      buf0 && $stable(buf0) |=> ($stable(ctrl_reg[1]) || !$past(buf0)))
      else $error("Channel 1 control changed while disabled");

   cap_block_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      cap_blk_reg[0] |-> !cap_pulse[0])
      else $error("Capture while inhibited");

   cmp_block_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      cmp_blk_reg[0] |-> !evt_pulse[0])
      else $error("Compare while inhibited");

   wrap_toggle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (wrap && ctrl_reg[0].toggle_on_wrap && ctrl_reg[0].mode_a && ctrl_reg[0].els_lo && !buf0)
      |=> ##1 channel_pin_out[0] != $past(channel_pin_out[0]))
      else $error("Overflow toggle missing");

   buf_swap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (wrap && buf0 && !tmr_reg[tcc_pkg::CLEAR_BIT]) |=> sel_reg != $past(sel_reg))
      else $error("Buffered register select did not swap");

   capture_value_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      cap_pulse[0] |=> value_reg[0] == $past(count_reg))
      else $error("Capture did not store counter");

   flag_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      status_reg[0] && !(psel && penable && pwrite && paddr == tcc_pkg::IRQ_CLR_OFS) |=> status_reg[0])
      else $error("Event flag lost without clear");

   irq_exact_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      irq == |(status_reg & enable_reg))
      else $error("Interrupt level does not follow flags");

   capture_edge_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      evt_pulse[0] && !ctrl_reg[0].mode_a && !buf0 |-> level[0] != $past(level[0]))
      else $error("Capture event without pin edge");

   rise_only_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      cap_pulse[0] && !ctrl_reg[0].els_hi |-> level[0])
      else $error("Rising capture on falling edge");

   fall_only_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      cap_pulse[0] && !ctrl_reg[0].els_lo |-> !level[0])
      else $error("Falling capture on rising edge");

   compare_equal_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      evt_pulse[0] && (ctrl_reg[0].mode_a || buf0) |-> count_reg == cmp_w[0])
      else $error("Compare event without equality");

   set_action_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (evt_pulse[0] && ctrl_reg[0].mode_a && ctrl_reg[0].els_hi && ctrl_reg[0].els_lo
      && !ctrl_reg[0].toggle_on_wrap && !buf0) |=> ##1 channel_pin_out[0])
      else $error("Set on compare did not raise pin");

   capture_no_drive_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!ctrl_reg[0].mode_a && !buf0) |-> ##2 !channel_pin_oe[0])
      else $error("Capture channel drives its pin");

   compare_drive_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (ctrl_reg[0].mode_a && (ctrl_reg[0].els_hi || ctrl_reg[0].els_lo)) |-> ##2 channel_pin_oe[0])
      else $error("Compare channel does not drive its pin");

   ch1_release_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      buf0 |-> ##2 !channel_pin_oe[1])
      else $error("Channel 1 pin driven in buffered mode");
endmodule // tcc_top

// [tcc_pin_model.sv]
// Far-side circuitry on the two channel pins: one held level per pin.
// Assumes the bench requests levels on rising edges of sys_clk.
module tcc_pin_model #(
   parameter int CH_NUM = 2
) (
   input wire logic sys_clk,
   input wire logic [CH_NUM-1:0] want_level,
   input wire logic [CH_NUM-1:0] pin_out,
   input wire logic [CH_NUM-1:0] pin_oe,
   output logic [CH_NUM-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [CH_NUM-1:0] hold_reg = '0;

   // stable pin levels
   // A level only moves on a clock edge and then holds for many cycles.
   always_ff @(posedge sys_clk) begin
      hold_reg <= want_level;
   end

   // The wire follows the channel while it drives, the circuitry otherwise.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & hold_reg);
endmodule // tcc_pin_model

// [tb_timer_channel_capture_compare.sv]
// Self-checking bench for the timer capture/compare block over APB.
// Assumes the pin model on the channel pins and a counter that wraps at 16'hffff.
module tb_timer_channel_capture_compare;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [7:0] ctrl;
      logic level;
      logic flag;
   } tcc_row_t;

   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irq;
   logic [1:0] pin_in, pin_out, pin_oe;
   logic [1:0] want_level = 2'h0;
   logic [31:0] rdat;
   logic rerr;
   logic [15:0] v1, v2;
   int error_cnt = 0;
   int cmp_count = 0;
   int n;
   tcc_row_t caps [7] = '{'{8'h04, 1'b1, 1'b1}, '{8'h04, 1'b0, 1'b0}, '{8'h08, 1'b1, 1'b0},
      '{8'h08, 1'b0, 1'b1}, '{8'h0c, 1'b1, 1'b1}, '{8'h0c, 1'b0, 1'b1}, '{8'h00, 1'b1, 1'b0}};
   tcc_row_t cmps [5] = '{'{8'h18, 1'b0, 1'b1}, '{8'h1c, 1'b1, 1'b1}, '{8'h14, 1'b0, 1'b1},
      '{8'h14, 1'b1, 1'b1}, '{8'h28, 1'b0, 1'b1}};

   tcc_top #(.CH_NUM(2)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
      .channel_pin_oe(pin_oe), .irq(irq));

   tcc_pin_model #(.CH_NUM(2)) pins (.sys_clk(sys_clk), .want_level(want_level),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic complete_run;
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic wait_cyc(input int k);
      repeat (k) @(posedge sys_clk);
   endtask

   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1) begin
         error_cnt++;
         complete_run();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic pulse;
      want_level[0] <= 1'b1;
      wait_cyc(12);
      want_level[0] <= 1'b0;
      wait_cyc(12);
   endtask

   task automatic read_val(output logic [15:0] v);
      apb(1'b0, tcc_pkg::CH0_HI_OFS, 32'h0);
      v[15:8] = rdat[7:0];
      apb(1'b0, tcc_pkg::CH0_LO_OFS, 32'h0);
      v[7:0] = rdat[7:0];
   endtask

   // Halts and clears the counter, then programs channel 0.
   task automatic set_ctrl(input logic [7:0] c);
      apb(1'b1, tcc_pkg::TMR_CTRL_OFS, 32'h3);
      apb(1'b1, tcc_pkg::CH0_CTRL_OFS, {24'h0, c});
      apb(1'b1, tcc_pkg::IRQ_CLR_OFS, 32'h3);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      apb(1'b0, tcc_pkg::CH0_CTRL_OFS, 32'h0);
      chk("ch0 ctrl reset", 32'h0, {24'h0, rdat[7:0]});
      apb(1'b0, tcc_pkg::CH1_CTRL_OFS, 32'h0);
      chk("ch1 ctrl reset", 32'h0, {24'h0, rdat[7:0]});
      apb(1'b0, tcc_pkg::TMR_CTRL_OFS, 32'h0);
      chk("timer ctrl reset", {30'h0, tcc_pkg::TMR_CTRL_RESET}, {30'h0, rdat[1:0]});
      apb(1'b0, tcc_pkg::IRQ_STAT_OFS, 32'h0);
      chk("status reset", 32'h0, {30'h0, rdat[1:0]});
      apb(1'b0, 8'h3c, 32'h0);
      chk_bit("unmapped error", 1'b1, rerr);
      chk("pin enable reset", 32'h0, {30'h0, pin_oe});
      foreach (caps[i]) begin
         apb(1'b1, tcc_pkg::CH0_CTRL_OFS, {24'h0, caps[i].ctrl});
         apb(1'b1, tcc_pkg::IRQ_CLR_OFS, 32'h3);
         want_level[0] <= caps[i].level;
         wait_cyc(12);
         apb(1'b0, tcc_pkg::IRQ_STAT_OFS, 32'h0);
         chk_bit("capture flag", caps[i].flag, rdat[0]);
         chk_bit("capture pin enable", 1'b0, pin_oe[0]);
      end
      want_level[0] <= 1'b0;
      apb(1'b1, tcc_pkg::IRQ_EN_OFS, 32'h1);
      set_ctrl(8'h04);
      apb(1'b1, tcc_pkg::TMR_CTRL_OFS, 32'h0);
      pulse();
      chk_bit("irq raised", 1'b1, irq);
      read_val(v1);
      apb(1'b0, tcc_pkg::CH0_HI_OFS, 32'h0);
      v2[15:8] = rdat[7:0];
      pulse();
      apb(1'b0, tcc_pkg::CH0_LO_OFS, 32'h0);
      v2[7:0] = rdat[7:0];
      chk("blocked capture", {16'h0, v1}, {16'h0, v2});
      pulse();
      read_val(v2);
      chk_bit("new capture", 1'b1, v2 != v1);
      apb(1'b1, tcc_pkg::IRQ_EN_OFS, 32'h0);
      wait_cyc(2);
      chk_bit("irq masked", 1'b0, irq);
      apb(1'b1, tcc_pkg::IRQ_EN_OFS, 32'h1);
      wait_cyc(2);
      chk_bit("irq unmasked", 1'b1, irq);
      apb(1'b1, tcc_pkg::IRQ_CLR_OFS, 32'h1);
      wait_cyc(2);
      chk_bit("irq cleared", 1'b0, irq);
      apb(1'b1, tcc_pkg::CH0_HI_OFS, 32'h0);
      apb(1'b1, tcc_pkg::CH0_LO_OFS, 32'h20);
      foreach (cmps[i]) begin
         set_ctrl(cmps[i].ctrl);
         apb(1'b1, tcc_pkg::TMR_CTRL_OFS, 32'h0);
         wait_cyc(80);
         chk_bit("compare pin", cmps[i].level, pin_out[0]);
         chk_bit("compare pin enable", 1'b1, pin_oe[0]);
         apb(1'b0, tcc_pkg::IRQ_STAT_OFS, 32'h0);
         chk_bit("compare flag", cmps[i].flag, rdat[0]);
      end
      apb(1'b1, tcc_pkg::CH1_CTRL_OFS, 32'h1c);
      apb(1'b0, tcc_pkg::CH1_CTRL_OFS, 32'h0);
      chk("ch1 ctrl locked", 32'h0, {24'h0, rdat[7:0]});
      chk_bit("ch1 pin released", 1'b0, pin_oe[1]);
      set_ctrl(8'h00);
      set_ctrl(8'h18);
      wait_cyc(4);
      chk_bit("preset high", 1'b1, pin_out[0]);
      set_ctrl(8'h10);
      set_ctrl(8'h1c);
      wait_cyc(4);
      chk_bit("preset low", 1'b0, pin_out[0]);
      apb(1'b1, tcc_pkg::CH0_HI_OFS, 32'h0);
      apb(1'b1, tcc_pkg::TMR_CTRL_OFS, 32'h0);
      wait_cyc(80);
      apb(1'b0, tcc_pkg::IRQ_STAT_OFS, 32'h0);
      chk_bit("match held off", 1'b0, rdat[0]);
      apb(1'b1, tcc_pkg::TMR_CTRL_OFS, 32'h3);
      apb(1'b1, tcc_pkg::CH0_LO_OFS, 32'h20);
      apb(1'b1, tcc_pkg::TMR_CTRL_OFS, 32'h0);
      wait_cyc(80);
      chk_bit("match after low", 1'b1, pin_out[0]);
      set_ctrl(8'h1e);
      apb(1'b1, tcc_pkg::CH0_HI_OFS, 32'hff);
      apb(1'b1, tcc_pkg::CH0_LO_OFS, 32'hff);
      apb(1'b1, tcc_pkg::TMR_CTRL_OFS, 32'h0);
      n = 0;
      while (pin_out[0] !== 1'b0 && n < 70000) begin
         @(posedge sys_clk);
         n++;
      end
      chk_bit("wrap toggle wins", 1'b0, pin_out[0]);
      complete_run();
   end
endmodule // tb_timer_channel_capture_compare
